//--- rtl/mdc_top.sv
// multichannel dma controller with axi4-lite registers and memory master
`timescale 1ns/1ps
`default_nettype none
module mdc_top
   import mdc_pkg::*;
#(
   parameter int CHANS = MDC_CHANS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output mdc_mreq_type m_req,
   input wire mdc_mrsp_type m_rsp,
   input wire logic [CHANS-1:0] periph_req,
   output logic [CHANS-1:0] periph_done,
   output logic irq
);
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_FETCH = 7'b0000010,
      ST_READ = 7'b0000100,
      ST_WRITE = 7'b0001000,
      ST_WBACK = 7'b0010000,
      ST_ERR = 7'b0100000,
      ST_NEXT = 7'b1000000
   } mdc_state_type;

   mdc_state_type state_reg;
   logic master_en_reg;
   logic [31:0] base_reg;
   logic [CHANS-1:0] attr_reg, chan_en_reg, swreq_reg, sw_done_reg, run_alt_reg;
   logic [CHANS-1:0] pdone_reg;
   logic err_reg;
   logic [4:0] ch_reg;
   logic [1:0] word_reg;
   logic [31:0] src_end_reg, dst_end_reg, data_reg;
   mdc_ctl_type ctl_reg;
   logic [19:0] idx_reg;
   logic [1:0] sel_reg;
   logic auto_run_reg;
   logic sw_run_reg;
   logic aw_got_reg, w_got_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   mdc_mreq_type req_reg;

   function automatic logic [31:0] item_addr(input logic [31:0] end_ptr,
         input logic [1:0] inc, input logic [19:0] left);
      logic [31:0] back;
      back = {12'h000, left} << inc;
      item_addr = (inc == MDC_INC_NONE) ? end_ptr : end_ptr - back;
   endfunction

   function automatic logic [31:0] desc_addr(input logic [31:0] base,
         input logic alt, input logic [4:0] ch, input logic [3:0] w);
      desc_addr = (base & MDC_BASE_MASK) | (alt ? MDC_ALT_OFS : 32'h0)
         | {23'h0, ch, w};
   endfunction

   // pending request: software, or peripheral line where attributes allow
   logic [CHANS-1:0] pending;
   logic any_pend;
   logic [4:0] pick;
   always_comb begin
      pending = chan_en_reg & (swreq_reg | (periph_req & ~attr_reg));
      any_pend = |pending;
      pick = 5'h0;
      for (int i = CHANS - 1; i >= 0; i--) begin
         if (pending[i]) begin
            pick = 5'(i);
         end
      end
   end

   // register bus: write path
   logic wr_fire, rd_fire;
   assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign rd_fire = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awaddr_reg <= 12'h000;
         wdata_reg <= 32'h0000_0000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= MDC_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (wr_fire) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_reg > MDC_OFS_DONE) ? MDC_RESP_DECERR : MDC_RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] ofs);
      wr_hit = (a & ~MDC_OFS_WIN[11:0] | (a & 12'h000)) == ofs;
   endfunction

   logic done_evt;
   logic [4:0] done_ch;
   logic halt_evt;
   assign done_evt = (state_reg == ST_WBACK) && m_rsp.ready && (ctl_reg.mode == MDC_MODE_STOP);
   assign done_ch = ch_reg;
   // any write leaves wstrb ignored: every register is a full word

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         master_en_reg <= 1'b0;
         base_reg <= 32'h0000_0000;
         attr_reg <= '0;
      end else if (wr_fire) begin
         if (awaddr_reg == MDC_OFS_CFG) master_en_reg <= wdata_reg[0];
         if (awaddr_reg == MDC_OFS_BASE) base_reg <= wdata_reg & MDC_BASE_MASK;
         if (awaddr_reg == MDC_OFS_ATTR_SET) attr_reg <= attr_reg | wdata_reg[CHANS-1:0];
         if (awaddr_reg == MDC_OFS_ATTR_CLR) attr_reg <= attr_reg & ~wdata_reg[CHANS-1:0];
      end
   end

   // channel enables: software set/clear, hardware clear on completion
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_en_reg <= '0;
      end else begin
         for (int i = 0; i < CHANS; i++) begin
            if (done_evt && done_ch == 5'(i)) chan_en_reg[i] <= 1'b0;
            if (wr_fire && awaddr_reg == MDC_OFS_EN_CLR && wdata_reg[i]) chan_en_reg[i] <= 1'b0;
            if (wr_fire && awaddr_reg == MDC_OFS_EN_SET && wdata_reg[i]) chan_en_reg[i] <= 1'b1;
         end
      end
   end

   // software requests held until the channel is served or disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         swreq_reg <= '0;
      end else begin
         for (int i = 0; i < CHANS; i++) begin
            if (!chan_en_reg[i] || (state_reg == ST_FETCH && ch_reg == 5'(i))) swreq_reg[i] <= 1'b0;
            if (wr_fire && awaddr_reg == MDC_OFS_SWREQ && wdata_reg[i]) swreq_reg[i] <= 1'b1;
         end
      end
   end

   // completion status: software done flags held until read, reading the done register services it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_done_reg <= '0;
         pdone_reg <= '0;
         err_reg <= 1'b0;
      end else begin
         for (int i = 0; i < CHANS; i++) begin
            pdone_reg[i] <= done_evt && done_ch == 5'(i) && !sw_run_reg;
            if (rd_fire && s_axi_araddr == MDC_OFS_DONE) sw_done_reg[i] <= 1'b0;
            if (done_evt && done_ch == 5'(i) && sw_run_reg) sw_done_reg[i] <= 1'b1;
         end
         if (wr_fire && awaddr_reg == MDC_OFS_ERR && wdata_reg[0]) err_reg <= 1'b0;
         if (state_reg == ST_ERR) err_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
         periph_done <= '0;
      end else begin
         irq <= err_reg || (|sw_done_reg);
         periph_done <= pdone_reg;
      end
   end

   // register bus: read path, one cycle answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= MDC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= MDC_RESP_OKAY;
            case (s_axi_araddr)
               MDC_OFS_CFG: s_axi_rdata <= {31'h0, master_en_reg};
               MDC_OFS_STAT: s_axi_rdata <= {20'h0, ctl_reg.mode, ch_reg, 3'h0, master_en_reg};
               MDC_OFS_BASE: s_axi_rdata <= base_reg;
               MDC_OFS_ALTBASE: s_axi_rdata <= base_reg | MDC_ALT_OFS;
               MDC_OFS_ATTR: s_axi_rdata <= 32'(attr_reg);
               MDC_OFS_EN: s_axi_rdata <= 32'(chan_en_reg);
               MDC_OFS_ERR: s_axi_rdata <= {31'h0, err_reg};
               MDC_OFS_DONE: s_axi_rdata <= 32'(sw_done_reg);
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  if (s_axi_araddr > MDC_OFS_DONE) s_axi_rresp <= MDC_RESP_DECERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // transfer engine
   logic [31:0] lane_wdata;
   logic [3:0] lane_strb;
   logic [31:0] s_addr, d_addr;
   assign s_addr = item_addr(src_end_reg, ctl_reg.sinc, idx_reg);
   assign d_addr = item_addr(dst_end_reg, ctl_reg.dinc, idx_reg);
   assign halt_evt = !master_en_reg || !chan_en_reg[ch_reg];

   mdc_lane u_lane (
      .size(ctl_reg.ssize),
      .addr_lo(d_addr[1:0]),
      .rdata(data_reg),
      .src_lo(s_addr[1:0]),
      .wdata(lane_wdata),
      .strb(lane_strb)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         ch_reg <= 5'h0;
         word_reg <= 2'h0;
         src_end_reg <= 32'h0;
         dst_end_reg <= 32'h0;
         data_reg <= 32'h0;
         ctl_reg <= '0;
         idx_reg <= 20'h0;
         auto_run_reg <= 1'b0;
         sw_run_reg <= 1'b0;
         run_alt_reg <= '0;
         req_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (master_en_reg && any_pend) begin
                  ch_reg <= pick;
                  auto_run_reg <= swreq_reg[pick];
                  // origin kept apart from auto mode: peripheral auto runs report on their line
                  sw_run_reg <= swreq_reg[pick];
                  word_reg <= 2'h0;
                  req_reg <= '{valid: 1'b1, write: 1'b0, strb: 4'hF, wdata: 32'h0,
                     addr: desc_addr(base_reg, run_alt_reg[pick], pick, MDC_W_SRC)};
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (m_rsp.error) begin
                  req_reg.valid <= 1'b0;
                  state_reg <= ST_ERR;
               end else if (m_rsp.rvalid) begin
                  word_reg <= word_reg + 2'h1;
                  req_reg.addr <= req_reg.addr + 32'h4;
                  if (word_reg == 2'h0) src_end_reg <= m_rsp.rdata;
                  if (word_reg == 2'h1) dst_end_reg <= m_rsp.rdata;
                  if (word_reg == 2'h2) begin
                     ctl_reg <= mdc_ctl_type'(m_rsp.rdata);
                     idx_reg <= m_rsp.rdata[MDC_CTL_CNT_LO +: 20];
                     if (m_rsp.rdata[2:0] == MDC_MODE_AUTO) auto_run_reg <= 1'b1;
                     // a stopped descriptor leaves no request dangling in idle
                     req_reg <= '{valid: m_rsp.rdata[2:0] != MDC_MODE_STOP, write: 1'b0,
                        strb: 4'hF, wdata: 32'h0,
                        addr: item_addr(src_end_reg, m_rsp.rdata[MDC_CTL_SINC_LO +: 2],
                        m_rsp.rdata[MDC_CTL_CNT_LO +: 20])};
                     state_reg <= (m_rsp.rdata[2:0] == MDC_MODE_STOP) ? ST_IDLE : ST_READ;
                  end
               end
            end
            ST_READ: begin
               if (m_rsp.error) begin
                  req_reg.valid <= 1'b0;
                  state_reg <= ST_ERR;
               end else if (m_rsp.rvalid) begin
                  data_reg <= m_rsp.rdata;
                  req_reg <= '{valid: 1'b0, write: 1'b1, strb: 4'hF, wdata: 32'h0, addr: d_addr};
                  state_reg <= ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (!req_reg.valid) begin
                  req_reg.valid <= 1'b1;
                  req_reg.wdata <= lane_wdata;
                  req_reg.strb <= lane_strb;
               end else if (m_rsp.error) begin
                  req_reg.valid <= 1'b0;
                  state_reg <= ST_ERR;
               end else if (m_rsp.ready) begin
                  req_reg.valid <= 1'b0;
                  state_reg <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (idx_reg == 20'h0) begin
                  // count reads zero and mode stopped when written back
                  ctl_reg.count_m1 <= 20'h0;
                  ctl_reg.mode <= MDC_MODE_STOP;
                  req_reg <= '{valid: 1'b1, write: 1'b1, strb: 4'hF,
                     wdata: {ctl_reg[31:24], 20'h0, ctl_reg.alt_flag, MDC_MODE_STOP},
                     addr: desc_addr(base_reg, run_alt_reg[ch_reg], ch_reg, MDC_W_CTL)};
                  state_reg <= ST_WBACK;
               end else if (halt_evt
                     || (!auto_run_reg && !periph_req[ch_reg])) begin
                  // pause: remaining count saved so it reads back live
                  ctl_reg.count_m1 <= idx_reg - 20'h1;
                  req_reg <= '{valid: 1'b1, write: 1'b1, strb: 4'hF,
                     wdata: {ctl_reg[31:24], idx_reg - 20'h1, ctl_reg[3:0]},
                     addr: desc_addr(base_reg, run_alt_reg[ch_reg], ch_reg, MDC_W_CTL)};
                  state_reg <= ST_WBACK;
               end else begin
                  idx_reg <= idx_reg - 20'h1;
                  req_reg <= '{valid: 1'b1, write: 1'b0, strb: 4'hF, wdata: 32'h0,
                     addr: item_addr(src_end_reg, ctl_reg.sinc, idx_reg - 20'h1)};
                  state_reg <= ST_READ;
               end
            end
            ST_WBACK: begin
               if (m_rsp.error) begin
                  req_reg.valid <= 1'b0;
                  state_reg <= ST_ERR;
               end else if (m_rsp.ready) begin
                  req_reg.valid <= 1'b0;
                  // descriptors with alt_flag set flip to the other descriptor once they complete
                  if (ctl_reg.mode == MDC_MODE_STOP && ctl_reg.alt_flag)
                     run_alt_reg[ch_reg] <= ~run_alt_reg[ch_reg];
                  state_reg <= ST_IDLE;
               end
            end
            ST_ERR: begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   assign m_req = req_reg;
   // flash is never addressed: lists must be in sram for the read path
   // are software obligations

endmodule // mdc_top
`default_nettype wire

//--- rtl/mdc_pkg.sv
// package for the multichannel dma controller: register map, fields, types
package mdc_pkg;
   localparam int MDC_ADDR_W = 32;
   localparam int MDC_DATA_W = 32;
   localparam int MDC_CHANS = 32;
   localparam int MDC_CH_W = 5;
   // register byte offsets
   localparam logic [11:0] MDC_OFS_CFG = 12'h000;
   localparam logic [11:0] MDC_OFS_STAT = 12'h004;
   localparam logic [11:0] MDC_OFS_BASE = 12'h008;
   localparam logic [11:0] MDC_OFS_ALTBASE = 12'h00C;
   localparam logic [11:0] MDC_OFS_SWREQ = 12'h014;
   localparam logic [11:0] MDC_OFS_ATTR_SET = 12'h018;
   localparam logic [11:0] MDC_OFS_ATTR_CLR = 12'h01C;
   localparam logic [11:0] MDC_OFS_ATTR = 12'h020;
   localparam logic [11:0] MDC_OFS_EN_SET = 12'h028;
   localparam logic [11:0] MDC_OFS_EN_CLR = 12'h02C;
   localparam logic [11:0] MDC_OFS_EN = 12'h030;
   localparam logic [11:0] MDC_OFS_ERR = 12'h04C;
   localparam logic [11:0] MDC_OFS_DONE = 12'h050;
   localparam logic [11:0] MDC_OFS_WIN = 12'h00F;
   // table geometry
   localparam int MDC_TABLE_BYTES = 1024;
   localparam int MDC_DESC_BYTES = 16;
   localparam logic [31:0] MDC_BASE_MASK = 32'hFFFF_FC00;
   localparam logic [31:0] MDC_ALT_OFS = 32'h0000_0200;
   localparam logic [3:0] MDC_W_SRC = 4'h0;
   localparam logic [3:0] MDC_W_DST = 4'h4;
   localparam logic [3:0] MDC_W_CTL = 4'h8;
   // control word fields
   localparam int MDC_CTL_MODE_LO = 0;
   localparam int MDC_CTL_CNT_LO = 4;
   localparam int MDC_CTL_SSIZE_LO = 24;
   localparam int MDC_CTL_SINC_LO = 26;
   localparam int MDC_CTL_DINC_LO = 30;
   localparam logic [2:0] MDC_MODE_STOP = 3'h0;
   localparam logic [2:0] MDC_MODE_BASIC = 3'h1;
   localparam logic [2:0] MDC_MODE_AUTO = 3'h2;
   localparam logic [2:0] MDC_MODE_PINGPONG = 3'h3;
   localparam logic [1:0] MDC_SIZE_8 = 2'h0;
   localparam logic [1:0] MDC_SIZE_16 = 2'h1;
   localparam logic [1:0] MDC_SIZE_32 = 2'h2;
   localparam logic [1:0] MDC_INC_NONE = 2'h3;
   localparam logic [1:0] MDC_RESP_OKAY = 2'h0;
   localparam logic [1:0] MDC_RESP_SLVERR = 2'h2;
   localparam logic [1:0] MDC_RESP_DECERR = 2'h3;
   typedef struct packed {
      logic [1:0] dinc;
      logic [1:0] dsize;
      logic [1:0] sinc;
      logic [1:0] ssize;
      logic [19:0] count_m1;
      logic alt_flag;
      logic [2:0] mode;
   } mdc_ctl_type;
   // simple memory master request/answer
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
      logic [3:0] strb;
   } mdc_mreq_type;
   typedef struct packed {
      logic ready;
      logic rvalid;
      logic [31:0] rdata;
      logic error;
   } mdc_mrsp_type;
endpackage

//--- rtl/mdc_lane.sv
// byte lane placement for an item of 8, 16 or 32 bits
`timescale 1ns/1ps
`default_nettype none
module mdc_lane
   import mdc_pkg::*;
(
   input wire logic [1:0] size,
   input wire logic [1:0] addr_lo,
   input wire logic [31:0] rdata,
   input wire logic [1:0] src_lo,
   output logic [31:0] wdata,
   output logic [3:0] strb
);
   logic [31:0] item;
   always_comb begin
      item = rdata >> {src_lo, 3'h0};
      wdata = item << {addr_lo, 3'h0};
      case (size)
         MDC_SIZE_8: strb = 4'h1 << addr_lo;
         MDC_SIZE_16: strb = 4'h3 << {addr_lo[1], 1'b0};
         default: strb = 4'hF;
      endcase
   end
endmodule // mdc_lane
`default_nettype wire

//--- testbench/mdc_properties.sv
// checker: bus handshake and completion properties of the dma controller
`timescale 1ns/1ps
`default_nettype none
module mdc_properties
   import mdc_pkg::*;
#(
   parameter int CHANS = MDC_CHANS
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire mdc_mreq_type m_req,
   input wire mdc_mrsp_type m_rsp,
   input wire logic [CHANS-1:0] periph_done
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // an unanswered memory request (fetch, data read, data write or write-back) must not move under the memory
   sequence s_mem_wait;
      m_req.valid && !m_rsp.ready && !m_rsp.rvalid && !m_rsp.error;
   endsequence
   chk_aw_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid))
      else $error("awready without awvalid");
   chk_b_follow: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_r_answer: assert property (s_ar_take |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
      else $error("arready longer than one cycle");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_req_hold: assert property (s_mem_wait |=> m_req.valid && $stable(m_req))
      else $error("memory request changed before answer");
   chk_done_pulse: assert property (|periph_done |=> (periph_done & $past(periph_done)) == '0)
      else $error("peripheral done longer than one cycle");
endmodule // mdc_properties
bind mdc_top mdc_properties #(.CHANS(CHANS)) i_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .m_req(m_req), .m_rsp(m_rsp),
   .periph_done(periph_done));
`default_nettype wire

//--- testbench/mdc_mem_model.sv
// memory partner: word sram answering the dma master after lat cycles
`timescale 1ns/1ps
`default_nettype none
module mdc_mem_model
   import mdc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] lat,
   input wire mdc_mreq_type req,
   output mdc_mrsp_type rsp
);
   // sram only, so task lists and the table live here
   logic [31:0] mem [0:1023];
   logic [3:0] wait_reg;
   always @(posedge aclk) begin
      rsp.ready <= 1'b0;
      rsp.rvalid <= 1'b0;
      rsp.error <= 1'b0;
      // idle data toggles so stale words never look valid
      rsp.rdata <= ~rsp.rdata;
      if (!aresetn) begin
         wait_reg <= 4'h0;
         rsp.rdata <= 32'h0;
      end else if (req.valid && !rsp.ready && !rsp.rvalid && !rsp.error) begin
         if (wait_reg < lat) begin
            wait_reg <= wait_reg + 4'h1;
         end else begin
            wait_reg <= 4'h0;
            // addresses past the sram answer with a bus error
            rsp.ready <= req.write && ~|req.addr[31:12];
            rsp.rvalid <= !req.write && ~|req.addr[31:12];
            rsp.error <= |req.addr[31:12];
            if (!req.write) rsp.rdata <= mem[req.addr[11:2]];
            for (int b = 0; b < 4; b++) begin
               if (req.write && req.strb[b] && ~|req.addr[31:12])
                  mem[req.addr[11:2]][8*b+:8] <= req.wdata[8*b+:8];
            end
         end
      end
   end
endmodule // mdc_mem_model
`default_nettype wire

//--- testbench/tb_mdc_top.sv
// testbench: register, software and peripheral transfers of the dma controller
`timescale 1ns/1ps
`default_nettype none
module tb_mdc_top
   import mdc_pkg::*;
;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, irq, seen;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val, preq, pdone;
   logic [1:0] bresp, rresp, rd_resp, wr_resp;
   logic [3:0] lat;
   mdc_mreq_type m_req;
   mdc_mrsp_type m_rsp;
   int err_count, samples_checked, cyc, n;
   mdc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .m_req(m_req), .m_rsp(m_rsp), .periph_req(preq), .periph_done(pdone), .irq(irq));
   mdc_mem_model i_mem (.aclk(aclk), .aresetn(aresetn), .lat(lat), .req(m_req), .rsp(m_rsp));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      wr_resp = bresp;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_val = rdata;
      rd_resp = rresp;
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("register %h", a), e, rd_val);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // whole run needs a few hundred cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
      {awaddr, araddr, wdata, preq, lat} = 92'h0;
      for (int i = 0; i < 4; i++) begin
         i_mem.mem[16+i] = 32'hC0DE_0000 + i;
         i_mem.mem[32+i] = 32'h0;
      end
      // end pointers, then control words: auto 4 words, basic 2 bytes
      i_mem.mem[256] = 32'h0000_004C;
      i_mem.mem[257] = 32'h0000_008C;
      i_mem.mem[258] = 32'hAA00_0032;
      i_mem.mem[260] = 32'h0000_00C1;
      i_mem.mem[261] = 32'h0000_00D1;
      i_mem.mem[262] = 32'h0000_0011;
      i_mem.mem[48] = 32'h0000_BBAA;
      i_mem.mem[52] = 32'h0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rc(MDC_OFS_CFG, 32'h0);
      rc(MDC_OFS_EN, 32'h0);
      rd(12'h100);
      chk("unmapped response", {30'h0, MDC_RESP_DECERR}, {30'h0, rd_resp});
      wr(MDC_OFS_BASE, 32'h0000_07FF);
      rc(MDC_OFS_BASE, 32'h0000_0400);
      rc(MDC_OFS_ALTBASE, 32'h0000_0600);
      wr(MDC_OFS_ATTR_SET, 32'h6);
      wr(MDC_OFS_ATTR_CLR, 32'h2);
      rc(MDC_OFS_ATTR, 32'h4);
      wr(MDC_OFS_ATTR_CLR, 32'h4);
      wr(MDC_OFS_EN_SET, 32'h21);
      wr(MDC_OFS_EN_CLR, 32'h20);
      rc(MDC_OFS_EN, 32'h1);
      wr(12'h100, 32'h0);
      chk("unmapped write response", {30'h0, MDC_RESP_DECERR}, {30'h0, wr_resp});
      $display("test registers done");
      wr(MDC_OFS_SWREQ, 32'h1);
      repeat (40) @(posedge aclk);
      chk("destination while off", 32'h0, i_mem.mem[32]);
      wr(MDC_OFS_CFG, 32'h1);
      wr(MDC_OFS_SWREQ, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      chk("software irq", 32'h1, {31'h0, irq});
      rc(MDC_OFS_EN, 32'h0);
      rc(MDC_OFS_DONE, 32'h1);
      rc(MDC_OFS_DONE, 32'h0);
      chk("irq after service", 32'h0, {31'h0, irq});
      for (int i = 0; i < 4; i++) chk("word copy", 32'hC0DE_0000 + i, i_mem.mem[32+i]);
      chk("control writeback", 32'hAA00_0000, i_mem.mem[258]);
      $display("test software transfer done");
      lat <= 4'h3;
      wr(MDC_OFS_EN_SET, 32'h2);
      preq <= 32'h2;
      seen = 1'b0;
      n = 0;
      while (seen !== 1'b1 && n < 2000) begin
         @(posedge aclk);
         seen = pdone[1];
         n++;
      end
      preq <= 32'h0;
      chk("peripheral done", 32'h1, {31'h0, seen});
      chk("irq on peripheral", 32'h0, {31'h0, irq});
      chk("byte copy", 32'h0000_BBAA, i_mem.mem[52]);
      rc(MDC_OFS_EN, 32'h0);
      $display("test peripheral transfer done");
      wr(MDC_OFS_BASE, 32'h0000_1000);
      wr(MDC_OFS_EN_SET, 32'h1);
      wr(MDC_OFS_SWREQ, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      chk("error irq", 32'h1, {31'h0, irq});
      rc(MDC_OFS_ERR, 32'h1);
      wr(MDC_OFS_ERR, 32'h1);
      rc(MDC_OFS_ERR, 32'h0);
      chk("irq after error clear", 32'h0, {31'h0, irq});
      $display("test bus error done");
      results();
   end
endmodule // tb_mdc_top
`default_nettype wire
